// File: src/hub_reset_link_power.sv
// chip reset combiner and upstream link power state sequencer
`default_nettype none
module hub_reset_link_power #(
    parameter int unsigned POR_CYC   = hub_rst_pkg::POR_HOLD_CYC,
    parameter int unsigned SUSP_IN   = hub_rst_pkg::SUSP_ENTRY_CYC,
    parameter int unsigned SUSP_OUT  = hub_rst_pkg::SUSP_EXIT_CYC
) (
    input  wire logic       MCLK,
    input  wire logic       RST,
    input  wire logic       RESET_N,
    input  wire logic       BUS_RESET,
    input  wire logic       HOST_REQ_SLEEP,
    input  wire logic       HOST_REQ_SUSPEND,
    input  wire logic       HOST_REQ_WAKE,
    input  wire logic       DEV_REQ_SLEEP,
    input  wire logic       DEV_REQ_SUSPEND,
    input  wire logic       DEV_REQ_WAKE,
    input  wire logic       SET_ADDR,
    input  wire logic [6:0] NEW_ADDR,
    input  wire logic       SET_CONFIG,
    output logic            CORE_RST,
    output logic            STANDBY,
    output logic            PHY_EN,
    output logic            DIFF_OE,
    output logic            XTAL_EN,
    output logic            PLL_EN,
    output logic            XFER_ABORT,
    output logic            DS_RESET,
    output logic [6:0]      DEV_ADDR,
    output logic            CONFIGURED,
    output logic [1:0]      LINK_STATE,
    output logic            LINK_BUSY
);
    // pin synchroniser, three stages; change counts when stages two and three agree
    logic [2:0] pin_sync_ff;
    logic [2:0] nxt_pin_sync;
    logic       pin_low_ff;
    logic       nxt_pin_low;
    logic [2:0] bus_sync_ff;
    logic [2:0] nxt_bus_sync;
    logic       bus_rst_ff;
    logic       nxt_bus_rst;

    always_comb begin
        nxt_pin_sync = {pin_sync_ff[1:0], RESET_N};
        nxt_bus_sync = {bus_sync_ff[1:0], BUS_RESET};
        nxt_pin_low  = pin_low_ff;
        nxt_bus_rst  = bus_rst_ff;
        if (pin_sync_ff[1] == pin_sync_ff[2]) begin
            nxt_pin_low = !pin_sync_ff[2];
        end
        if (bus_sync_ff[1] == bus_sync_ff[2]) begin
            nxt_bus_rst = bus_sync_ff[2];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_sync_ff <= 3'h7;
            bus_sync_ff <= 3'h0;
            pin_low_ff  <= 1'b0;
            bus_rst_ff  <= 1'b0;
        end else begin
            pin_sync_ff <= nxt_pin_sync;
            bus_sync_ff <= nxt_bus_sync;
            pin_low_ff  <= nxt_pin_low;
            bus_rst_ff  <= nxt_bus_rst;
        end
    end

    // power-on hold timer, restarted by RST (power applied) and the pin
    logic [hub_rst_pkg::CNT_W-1:0] por_cnt_ff;
    logic [hub_rst_pkg::CNT_W-1:0] nxt_por_cnt;
    logic                         por_act_ff;
    logic                         nxt_por_act;
    logic                         core_rst_ff;
    logic                         nxt_core_rst;

    always_comb begin
        nxt_por_cnt  = por_cnt_ff;
        nxt_por_act  = por_act_ff;
        if (pin_low_ff) begin
            nxt_por_cnt = '0;
            nxt_por_act = 1'b1;
        end else if (por_act_ff) begin
            if (por_cnt_ff >= POR_CYC[hub_rst_pkg::CNT_W-1:0] - 1'b1) begin
                nxt_por_act = 1'b0;
            end else begin
                nxt_por_cnt = por_cnt_ff + 1'b1;
            end
        end
        nxt_core_rst = pin_low_ff || por_act_ff || bus_rst_ff;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            por_cnt_ff  <= '0;
            por_act_ff  <= 1'b1;
            core_rst_ff <= 1'b1;
        end else begin
            por_cnt_ff  <= nxt_por_cnt;
            por_act_ff  <= nxt_por_act;
            core_rst_ff <= nxt_core_rst;
        end
    end

    assign CORE_RST   = core_rst_ff;
    assign STANDBY    = pin_low_ff;
    assign PHY_EN     = !pin_low_ff && !por_act_ff;
    assign DIFF_OE    = PHY_EN;
    assign XTAL_EN    = !pin_low_ff;
    assign PLL_EN     = !pin_low_ff;
    assign XFER_ABORT = pin_low_ff || bus_rst_ff;
    assign DS_RESET   = 1'b0;

    // address and configuration state
    logic [6:0] addr_ff;
    logic [6:0] nxt_addr;
    logic       cfg_ff;
    logic       nxt_cfg;
    logic       local_rst;
    assign local_rst = pin_low_ff || por_act_ff;

    always_comb begin
        nxt_addr = addr_ff;
        nxt_cfg  = cfg_ff;
        if (local_rst || bus_rst_ff) begin
            nxt_addr = hub_rst_pkg::ADDR_RESET;
            nxt_cfg  = 1'b0;
        end else begin
            if (SET_ADDR) begin
                nxt_addr = NEW_ADDR;
            end
            if (SET_CONFIG) begin
                nxt_cfg = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            addr_ff <= hub_rst_pkg::ADDR_RESET;
            cfg_ff  <= 1'b0;
        end else begin
            addr_ff <= nxt_addr;
            cfg_ff  <= nxt_cfg;
        end
    end

    assign DEV_ADDR   = addr_ff;
    assign CONFIGURED = cfg_ff;

    // link power state machine
    typedef enum logic [2:0] {
        ST_ON,
        ST_SLEEP_IN,
        ST_SLEEP,
        ST_SUSP_IN,
        ST_SUSP,
        ST_WAKE
    } lp_state_e;

    lp_state_e                    st_ff;
    lp_state_e                    nxt_st;
    hub_rst_pkg::link_state_e     lnk_ff;
    hub_rst_pkg::link_state_e     nxt_lnk;
    timer_if                      tif ();
    logic                         tmr_rst;
    assign tmr_rst = RST || local_rst || bus_rst_ff;

    lat_timer u_timer (
        .clk (MCLK),
        .rst (tmr_rst),
        .t   (tif.tmr)
    );

    logic req_sleep;
    logic req_susp;
    logic req_wake;
    assign req_sleep = HOST_REQ_SLEEP || DEV_REQ_SLEEP;
    assign req_susp  = HOST_REQ_SUSPEND || DEV_REQ_SUSPEND;
    assign req_wake  = HOST_REQ_WAKE || DEV_REQ_WAKE;

    always_comb begin
        nxt_st     = st_ff;
        nxt_lnk    = lnk_ff;
        tif.start  = 1'b0;
        tif.load   = '0;
        if (local_rst || bus_rst_ff) begin
            nxt_st  = ST_ON;
            nxt_lnk = hub_rst_pkg::LINK_FULL_ON;
        end else begin
            unique case (st_ff)
                ST_ON: begin
                    if (req_susp) begin
                        nxt_st    = ST_SUSP_IN;
                        tif.start = 1'b1;
                        tif.load  = hub_rst_pkg::CNT_W'(SUSP_IN - 1);
                    end else if (req_sleep) begin
                        nxt_st    = ST_SLEEP_IN;
                        tif.start = 1'b1;
                        tif.load  = hub_rst_pkg::CNT_W'(hub_rst_pkg::SLEEP_ENTRY_CYC - 1);
                    end
                end
                ST_SLEEP_IN: begin
                    if (tif.done) begin
                        nxt_st  = ST_SLEEP;
                        nxt_lnk = hub_rst_pkg::LINK_SLEEP_STATE;
                    end
                end
                ST_SUSP_IN: begin
                    if (tif.done) begin
                        nxt_st  = ST_SUSP;
                        nxt_lnk = hub_rst_pkg::LINK_SUSPEND_STATE;
                    end
                end
                ST_SLEEP: begin
                    if (req_wake) begin
                        nxt_st    = ST_WAKE;
                        tif.start = 1'b1;
                        tif.load  = hub_rst_pkg::CNT_W'(hub_rst_pkg::SLEEP_EXIT_CYC - 1);
                    end
                end
                ST_SUSP: begin
                    if (req_wake) begin
                        nxt_st    = ST_WAKE;
                        tif.start = 1'b1;
                        tif.load  = hub_rst_pkg::CNT_W'(SUSP_OUT - 1);
                    end
                end
                ST_WAKE: begin
                    if (tif.done) begin
                        nxt_st  = ST_ON;
                        nxt_lnk = hub_rst_pkg::LINK_FULL_ON;
                    end
                end
                default: begin
                    nxt_st = ST_ON;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_ff  <= ST_ON;
            lnk_ff <= hub_rst_pkg::LINK_FULL_ON;
        end else begin
            st_ff  <= nxt_st;
            lnk_ff <= nxt_lnk;
        end
    end

    assign LINK_STATE = lnk_ff;
    assign LINK_BUSY  = (st_ff == ST_SLEEP_IN) || (st_ff == ST_SUSP_IN) || (st_ff == ST_WAKE);
endmodule
`default_nettype wire

// File: pkg/hub_rst_pkg.sv
// constants and types for the hub reset and link power sequencer
`default_nettype none
package hub_rst_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    // power-on hold time in microseconds
    localparam int unsigned POR_HOLD_US     = 100;
    localparam int unsigned POR_HOLD_CYC    = (POR_HOLD_US * (CLK_HZ / 1_000_000));
    // sleep entry under 10 us, exit under 50 us: longest times round down
    localparam int unsigned SLEEP_ENTRY_NS  = 10_000;
    localparam int unsigned SLEEP_EXIT_NS   = 50_000;
    localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;
    localparam int unsigned SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS / CLK_NS) - 1;
    localparam int unsigned SLEEP_EXIT_CYC  = (SLEEP_EXIT_NS / CLK_NS) - 1;
    // suspend entry about 3 ms, resume about 2 ms
    localparam int unsigned SUSP_ENTRY_US   = 3_000;
    localparam int unsigned SUSP_EXIT_US    = 2_000;
    localparam int unsigned SUSP_ENTRY_CYC  = SUSP_ENTRY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SUSP_EXIT_CYC   = SUSP_EXIT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W           = 24;
    localparam logic [6:0]  ADDR_RESET      = 7'h00;
    typedef enum logic [1:0] {
        LINK_FULL_ON,
        LINK_SLEEP_STATE,
        LINK_SUSPEND_STATE
    } link_state_e;
endpackage
`default_nettype wire

// File: pkg/timer_if.sv
// interface between the link sequencer and its latency timer
`default_nettype none
interface timer_if;
    logic                         start;
    logic [hub_rst_pkg::CNT_W-1:0] load;
    logic                         done;
    modport ctrl (output start, output load, input done);
    modport tmr  (input start, input load, output done);
endinterface
`default_nettype wire

// File: src/lat_timer.sv
// down counter that times link state transitions
`default_nettype none
module lat_timer (
    input  wire logic clk,
    input  wire logic rst,
    timer_if.tmr      t
);
    logic [hub_rst_pkg::CNT_W-1:0] cnt_ff;
    logic [hub_rst_pkg::CNT_W-1:0] nxt_cnt;
    logic                         run_ff;
    logic                         nxt_run;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_run = run_ff;
        if (t.start) begin
            nxt_cnt = t.load;
            nxt_run = 1'b1;
        end else if (run_ff) begin
            if (cnt_ff == '0) begin
                nxt_run = 1'b0;
            end else begin
                nxt_cnt = cnt_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            run_ff <= nxt_run;
        end
    end

    assign t.done = run_ff && (cnt_ff == '0) && !t.start;
endmodule
`default_nettype wire

// File: tb/hub_host_model.sv
// upstream host model: bus reset and link power requests
`default_nettype none
module hub_host_model (
    input  wire logic clk,
    output logic      bus_reset,
    output logic      req_sleep,
    output logic      req_suspend,
    output logic      req_wake
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        bus_reset = 1'b0;
        {req_sleep, req_suspend, req_wake} = 3'h0;
    end
    // one-cycle request: 1 sleep, 2 suspend, 0 wake
    task automatic request(input logic [1:0] k);
        @(posedge clk);
        {req_sleep, req_suspend, req_wake} <= {k == 2'h1, k == 2'h2, k == 2'h0};
        @(posedge clk);
        {req_sleep, req_suspend, req_wake} <= 3'h0;
        #1;
    endtask
    task automatic send_reset(input int n);
        @(posedge clk);
        bus_reset <= 1'b1;
        repeat (n) @(posedge clk);
        bus_reset <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// File: tb/hub_rst_asserts.sv
// port assertions for the reset and link power sequencer
`default_nettype none
module hub_rst_chk #(
    parameter int POR_CYC  = 20,
    parameter int SUSP_IN  = 30,
    parameter int SUSP_OUT = 20
) (
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       BUS_RESET,
    input wire logic       CORE_RST,
    input wire logic       STANDBY,
    input wire logic       PHY_EN,
    input wire logic       DIFF_OE,
    input wire logic       XTAL_EN,
    input wire logic       PLL_EN,
    input wire logic       XFER_ABORT,
    input wire logic       DS_RESET,
    input wire logic [6:0] DEV_ADDR,
    input wire logic       CONFIGURED,
    input wire logic [1:0] LINK_STATE,
    input wire logic       LINK_BUSY
);
    localparam int PO_LO = POR_CYC - 8;
    localparam int PO_HI = POR_CYC - 4;
    localparam int EN_HI = (SUSP_IN > 249) ? SUSP_IN + 1 : 250;
    localparam int SO_LO = SUSP_OUT - 1;
    localparam int SO_HI = SUSP_OUT + 1;
    logic [11:0] busy_cnt_ff;
    logic [11:0] nxt_busy_cnt;
    always_comb begin
        nxt_busy_cnt = LINK_BUSY ? busy_cnt_ff + 12'h001 : 12'h000;
    end
    always_ff @(posedge MCLK) begin
        busy_cnt_ff <= RST ? 12'h000 : nxt_busy_cnt;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_enter;
        $rose(LINK_BUSY) && LINK_STATE == 2'h0;
    endsequence
    sequence s_resume;
        $rose(LINK_BUSY) && LINK_STATE == 2'h2;
    endsequence
    property p_no_fwd; DS_RESET == 1'b0; endproperty
    property p_stby_off; STANDBY |-> !PHY_EN && !DIFF_OE && !XTAL_EN && !PLL_EN; endproperty
    property p_stby_hold; STANDBY [*2] |-> CORE_RST && XFER_ABORT; endproperty
    property p_bus; $rose(BUS_RESET) |-> ##[1:8] (DEV_ADDR == 7'h00 && !CONFIGURED && LINK_STATE == 2'h0); endproperty
    property p_enter; s_enter |-> ##[1:EN_HI] LINK_STATE != 2'h0; endproperty
    property p_resume; s_resume |-> ##[SO_LO:SO_HI] LINK_STATE == 2'h0; endproperty
    property p_busy; busy_cnt_ff <= 12'h4E2; endproperty
    property p_por; $fell(RST) |-> CORE_RST [*8] ##[PO_LO:PO_HI] !CORE_RST; endproperty
    a_no_fwd: assert property (p_no_fwd) else $error("reset forwarded");
    a_stby_off: assert property (p_stby_off) else $error("standby clocks or phy on");
    a_stby_hold: assert property (p_stby_hold) else $error("standby without reset");
    a_bus: assert property (p_bus) else $error("bus reset state");
    a_enter: assert property (p_enter) else $error("entry late");
    a_resume: assert property (p_resume) else $error("resume time");
    a_busy: assert property (p_busy) else $error("busy too long");
    a_por: assert property (p_por) else $error("power-on hold");
endmodule
bind hub_reset_link_power hub_rst_chk #(.POR_CYC(POR_CYC), .SUSP_IN(SUSP_IN), .SUSP_OUT(SUSP_OUT)) hub_rst_chk_i (
    .MCLK(MCLK), .RST(RST), .BUS_RESET(BUS_RESET), .CORE_RST(CORE_RST), .STANDBY(STANDBY),
    .PHY_EN(PHY_EN), .DIFF_OE(DIFF_OE), .XTAL_EN(XTAL_EN), .PLL_EN(PLL_EN), .XFER_ABORT(XFER_ABORT),
    .DS_RESET(DS_RESET), .DEV_ADDR(DEV_ADDR), .CONFIGURED(CONFIGURED), .LINK_STATE(LINK_STATE),
    .LINK_BUSY(LINK_BUSY));
`default_nettype wire

// File: tb/hub_reset_link_power_test.sv
// testbench for the reset and link power sequencer
`default_nettype none
module hub_reset_link_power_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POR = 20;
    localparam int SIN = 30;
    localparam int SOUT = 20;
    logic       mclk, rst, rst_n, set_addr, set_cfg, d_slp, d_sus, d_wak;
    logic [6:0] new_addr, dev_addr;
    logic [1:0] lst;
    logic       core_rst, stby, phy_en, diff_oe, xtal_en, pll_en, abort, ds_rst, cfgd, busy;
    wire logic  b_rst, h_slp, h_sus, h_wak;
    int         err_count = 0;
    int         num_checks = 0;
    int         c;
    hub_host_model hub_host_model_i (.clk(mclk), .bus_reset(b_rst), .req_sleep(h_slp), .req_suspend(h_sus),
        .req_wake(h_wak));
    hub_reset_link_power #(.POR_CYC(POR), .SUSP_IN(SIN), .SUSP_OUT(SOUT)) hub_reset_link_power_i (
        .MCLK(mclk), .RST(rst), .RESET_N(rst_n), .BUS_RESET(b_rst), .HOST_REQ_SLEEP(h_slp),
        .HOST_REQ_SUSPEND(h_sus), .HOST_REQ_WAKE(h_wak), .DEV_REQ_SLEEP(d_slp), .DEV_REQ_SUSPEND(d_sus),
        .DEV_REQ_WAKE(d_wak), .SET_ADDR(set_addr), .NEW_ADDR(new_addr), .SET_CONFIG(set_cfg),
        .CORE_RST(core_rst), .STANDBY(stby), .PHY_EN(phy_en), .DIFF_OE(diff_oe), .XTAL_EN(xtal_en),
        .PLL_EN(pll_en), .XFER_ABORT(abort), .DS_RESET(ds_rst), .DEV_ADDR(dev_addr), .CONFIGURED(cfgd),
        .LINK_STATE(lst), .LINK_BUSY(busy));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [6:0] e, input logic [6:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wait_link(input logic [1:0] st, input int lim);
        for (c = 0; lst !== st && c < lim; c++) begin
            cyc(1);
        end
        if (c >= lim) begin
            chk("link_wait", {5'h00, st}, {5'h00, lst});
            end_of_test();
        end
    endtask
    task automatic wait_run(input int lim);
        for (c = 0; core_rst !== 1'b0 && c < lim; c++) begin
            cyc(1);
        end
        chk("core_rst", 7'h00, {6'h00, core_rst});
        if (core_rst !== 1'b0) begin
            end_of_test();
        end
    endtask
    task automatic dev_req(input logic [1:0] k);
        @(posedge mclk);
        {d_slp, d_sus, d_wak} <= {k == 2'h1, k == 2'h2, k == 2'h0};
        @(posedge mclk);
        {d_slp, d_sus, d_wak} <= 3'h0;
        #1;
    endtask
    task automatic configure(input logic [6:0] a);
        @(posedge mclk);
        {set_addr, set_cfg, new_addr} <= {2'h3, a};
        @(posedge mclk);
        {set_addr, set_cfg} <= 2'h0;
        cyc(2);
        chk("dev_addr", a, dev_addr);
        chk("configured", 7'h01, {6'h00, cfgd});
    endtask
    task automatic t_power_on();
        wait_run(POR + 10);
        chk("por_hold", 7'h01, {6'h00, c >= POR && c <= POR + 3});
        chk("addr_dflt", 7'h00, dev_addr);
        chk("link_dflt", 7'h00, {5'h00, lst});
        chk("clocks_run", 7'h03, {5'h00, xtal_en, pll_en});
        $display("power_on done");
    endtask
    task automatic t_sleep();
        dev_req(2'h1);
        chk("sleep_busy", 7'h01, {6'h00, busy});
        wait_link(2'h1, 300);
        chk("sleep_entry", 7'h01, {6'h00, c < 250});
        chk("sleep_idle", 7'h00, {6'h00, busy});
        hub_host_model_i.request(2'h0);
        wait_link(2'h0, 1300);
        chk("sleep_exit", 7'h01, {6'h00, c < 1250});
        $display("sleep done");
    endtask
    task automatic t_host_sleep();
        hub_host_model_i.request(2'h1);
        chk("host_busy", 7'h01, {6'h00, busy});
        wait_link(2'h1, 300);
        chk("host_sleep", 7'h01, {6'h00, c < 250});
        dev_req(2'h0);
        wait_link(2'h0, 1300);
        chk("dev_wake", 7'h01, {6'h00, c < 1250});
        $display("host sleep done");
    endtask
    task automatic t_susp_bus();
        configure(7'h2A);
        hub_host_model_i.request(2'h2);
        wait_link(2'h2, 60);
        chk("susp_entry", 7'h01, {6'h00, c >= SIN && c <= SIN + 2});
        hub_host_model_i.send_reset(6);
        cyc(1);
        chk("bus_addr", 7'h00, dev_addr);
        chk("bus_cfg", 7'h00, {6'h00, cfgd});
        chk("bus_link", 7'h00, {5'h00, lst});
        chk("ds_reset", 7'h00, {6'h00, ds_rst});
        wait_run(POR + 20);
        $display("suspend bus reset done");
    endtask
    task automatic t_resume();
        dev_req(2'h2);
        wait_link(2'h2, 60);
        dev_req(2'h0);
        wait_link(2'h0, 60);
        chk("resume", 7'h01, {6'h00, c >= SOUT && c <= SOUT + 2});
        $display("resume done");
    endtask
    task automatic t_pin();
        configure(7'h55);
        @(posedge mclk);
        rst_n <= 1'b0;
        cyc(6);
        chk("standby", 7'h01, {6'h00, stby});
        chk("phy_off", 7'h00, {5'h00, phy_en, diff_oe});
        chk("abort", 7'h01, {6'h00, abort});
        chk("pin_addr", 7'h00, dev_addr);
        chk("clk_stop", 7'h00, {5'h00, xtal_en, pll_en});
        chk("pin_hold", 7'h01, {6'h00, core_rst});
        @(posedge mclk);
        rst_n <= 1'b1;
        wait_run(POR + 20);
        chk("phy_on", 7'h03, {5'h00, phy_en, diff_oe});
        $display("pin reset done");
    endtask
    initial begin
        {rst, rst_n, set_addr, set_cfg, d_slp, d_sus, d_wak} = 7'h60;
        new_addr = 7'h00;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_power_on();
        t_sleep();
        t_susp_bus();
        t_resume();
        t_host_sleep();
        t_pin();
        end_of_test();
    end
endmodule
`default_nettype wire
